// ==== shared/fob_defs.vh ====
`ifndef FOB_DEFS_VH
`define FOB_DEFS_VH

// Register indexes; byte address is index times four
`define FOB_IDX_TRIM_INDEX  12'hFF6
`define FOB_IDX_TRIM_DATA   12'hFF7
`define FOB_IDX_OPT_STATUS  12'hFF0
`define FOB_IDX_LIVE_STATUS 12'hFF1

// Flash locations of the option and trim bytes
`define FOB_FLASH_OPT0      16'h0000
`define FOB_FLASH_OPT1      16'h0001
`define FOB_FLASH_TRIM_BASE 16'h0020

// Trim window
`define FOB_TRIM_LAST       8'h1F
`define FOB_LOAD_LAST       6'h21

// Option byte 0 field positions
`define FOB_B0_WDT_ACTION   7
`define FOB_B0_WATCHDOG_ALWAYS_ON_SEL       6
`define FOB_B0_BO_AO        3
`define FOB_B0_READ_PROT    2
`define FOB_B0_WRITE_PROT   0

// Option byte 1 field positions
`define FOB_B1_XTAL_OFF     4

// Reserved bit masks, read back as ones
`define FOB_B0_RSVD_MASK    8'h32
`define FOB_B1_RSVD_MASK    8'hEF

// Reset values
`define FOB_ERASED_BYTE     8'hFF
`define FOB_TRIM_DATA_RST   8'h00
`define FOB_TRIM_INDEX_RST  8'h00

// Bus responses
`define FOB_RESP_OKAY       2'h0
`define FOB_RESP_SLVERR     2'h2

`endif

// ==== logic/fob_option_config.v ====
// Summary of operation
// [RULE1] Trim data register at FF7H, resets zero
// [RULE2] Options come from flash bytes 0000H, 0001H
// [RULE3] Action bit 0: timeout raises interrupt request
// [RULE4] Action bit 1: timeout forces system reset
// [RULE5] Always-on bit 0: watchdog runs, unstoppable
// [RULE6] Bit 1: start by instruction, reset stops
// [RULE7] Brownout off in stop only with power bit
// [RULE8] Brownout bit 1: protection always active
// [RULE9] Read protect 0: code blocked, limited debug
// [RULE10] Read protect 1: code readable, full debug
// [RULE11] Write protect 0: user programming refused
// [RULE12] Write protect 1: programming and erase allowed
// [RULE13] Reserved option bits read back as one
// [RULE14] Crystal bit 0: oscillator runs in reset
// [RULE15] Crystal bit 1: oscillator off in reset
// [RULE16] Software selects crystal as clock itself
// [RULE17] Trim index 0 maps 0020H, write-protected
// [RULE18] Options loaded on every reset before run
// [RULE19] Index 00H-1FH, then data write updates
// [RULE20] Index load, then data read returns value
// [RULE21] Working trims reloaded on any reset
// [RULE22] Latched options constant between resets
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fob_defs.vh"
`default_nettype none

module fob_option_config #(
    parameter AXI_AW     = 14,
    parameter TRIM_BYTES = 32
) (
    // Clock and reset
    input  wire              i_ref_clk,
    input  wire              i_rst,
    // AXI4-Lite write address
    input  wire [AXI_AW-1:0] i_s_axi_awaddr,
    input  wire              i_s_axi_awvalid,
    output reg               o_s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       i_s_axi_wdata,
    input  wire [3:0]        i_s_axi_wstrb,
    input  wire              i_s_axi_wvalid,
    output reg               o_s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        o_s_axi_bresp,
    output reg               o_s_axi_bvalid,
    input  wire              i_s_axi_bready,
    // AXI4-Lite read address
    input  wire [AXI_AW-1:0] i_s_axi_araddr,
    input  wire              i_s_axi_arvalid,
    output reg               o_s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       o_s_axi_rdata,
    output reg  [1:0]        o_s_axi_rresp,
    output reg               o_s_axi_rvalid,
    input  wire              i_s_axi_rready,
    // Flash read port
    output reg               o_flash_rd,
    output reg               o_flash_info,
    output reg  [15:0]       o_flash_addr,
    input  wire [7:0]        i_flash_rdata,
    input  wire              i_flash_rvalid,
    // System events
    input  wire              i_stop_recover,
    input  wire              i_stop_mode,
    input  wire              i_pwr_bo_stop_off,
    input  wire              i_watchdog_start_instruction,
    input  wire              i_wdt_timeout,
    // Configuration outputs
    output reg               o_opt_loaded,
    output reg               o_wdt_run,
    output reg               o_wdt_irq_req,
    output reg               o_wdt_sys_reset,
    output reg               o_bo_enable,
    output reg               o_code_read_ok,
    output reg               o_dbg_full,
    output reg               o_user_prog_ok,
    output reg               o_dbg_mass_erase_ok,
    output reg               o_xtal_run_in_reset
);

    localparam ST_LOAD = 1'b0;
    localparam ST_RUN  = 1'b1;

    // Loader state
    reg        state_q;
    reg [5:0]  load_cnt_q;
    reg [7:0]  user_option_byte_0_q;
    reg [7:0]  user_option_byte_1_q;

    // Working trim copy; no reset, reloaded by the loader
    reg [7:0]  trim_mem_q [0:TRIM_BYTES-1];

    // Software visible trim registers
    reg [7:0]  trim_index_register_q;
    reg [7:0]  trim_data_port_q;

    // Write channel capture
    reg        aw_have_q;
    reg [11:0] aw_idx_q;
    reg        w_have_q;
    reg [7:0]  w_byte_q;
    reg        w_lane0_q;

    wire       wr_fire;
    wire       idx_ok;
    wire       data_ok;
    wire       wr_trim_data;
    wire [5:0] trim_slot;
    wire [11:0] ar_idx;

    assign wr_fire   = aw_have_q & w_have_q & ~o_s_axi_bvalid;
    assign idx_ok    = (trim_index_register_q <= `FOB_TRIM_LAST);
    // Slot 0 is kept factory-only
    assign data_ok   = idx_ok & (trim_index_register_q != 8'h00)
                       & (state_q == ST_RUN); // RULE17
    assign wr_trim_data = wr_fire & w_lane0_q
                          & (aw_idx_q == `FOB_IDX_TRIM_DATA) & data_ok; // RULE19
    assign trim_slot = load_cnt_q - 6'h02;
    assign ar_idx    = i_s_axi_araddr[13:2];

    // Option and trim loader
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q              <= ST_LOAD;
            load_cnt_q           <= 6'h00;
            o_flash_rd           <= 1'b0;
            o_flash_info         <= 1'b0;
            o_flash_addr         <= `FOB_FLASH_OPT0;
            user_option_byte_0_q <= `FOB_ERASED_BYTE;
            user_option_byte_1_q <= `FOB_ERASED_BYTE;
            o_opt_loaded         <= 1'b0;
        end else begin
            case (state_q)
                ST_LOAD: begin
                    if (o_flash_rd && i_flash_rvalid) begin
                        o_flash_rd <= 1'b0;
                        if (load_cnt_q == 6'h00) begin
                            user_option_byte_0_q <= i_flash_rdata; // RULE2
                        end else if (load_cnt_q == 6'h01) begin
                            user_option_byte_1_q <= i_flash_rdata; // RULE2
                        end
                        if (load_cnt_q == `FOB_LOAD_LAST) begin
                            state_q      <= ST_RUN;
                            o_opt_loaded <= 1'b1; // RULE18
                        end else begin
                            load_cnt_q <= load_cnt_q + 6'h01;
                        end
                    end else if (!o_flash_rd) begin
                        o_flash_rd <= 1'b1;
                        if (load_cnt_q == 6'h00) begin
                            o_flash_info <= 1'b0;
                            o_flash_addr <= `FOB_FLASH_OPT0;
                        end else if (load_cnt_q == 6'h01) begin
                            o_flash_info <= 1'b0;
                            o_flash_addr <= `FOB_FLASH_OPT1;
                        end else begin
                            o_flash_info <= 1'b1;
                            o_flash_addr <= `FOB_FLASH_TRIM_BASE
                                            + {10'h000, trim_slot}; // RULE17
                        end
                    end
                end
                ST_RUN: begin
                    // Options frozen until the next reset or recovery
                    if (i_stop_recover) begin
                        state_q      <= ST_LOAD; // RULE22
                        load_cnt_q   <= 6'h00;
                        o_opt_loaded <= 1'b0; // RULE18
                    end
                end
                default: begin
                    state_q <= ST_LOAD;
                end
            endcase
        end
    end

    // Working trim array: loader fill and software update
    always @(posedge i_ref_clk) begin
        if (state_q == ST_LOAD && o_flash_rd && i_flash_rvalid
            && load_cnt_q >= 6'h02) begin
            trim_mem_q[trim_slot[4:0]] <= i_flash_rdata; // RULE21
        end else if (wr_trim_data) begin
            trim_mem_q[trim_index_register_q[4:0]] <= w_byte_q; // RULE19
        end
    end

    // Write channel
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_bresp   <= `FOB_RESP_OKAY;
            aw_have_q       <= 1'b0;
            aw_idx_q        <= 12'h000;
            w_have_q        <= 1'b0;
            w_byte_q        <= 8'h00;
            w_lane0_q       <= 1'b0;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_have_q       <= 1'b1;
                aw_idx_q        <= i_s_axi_awaddr[13:2];
                o_s_axi_awready <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_have_q       <= 1'b1;
                w_byte_q       <= i_s_axi_wdata[7:0];
                w_lane0_q      <= i_s_axi_wstrb[0];
                o_s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q      <= 1'b0;
                w_have_q       <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                case (aw_idx_q)
                    `FOB_IDX_TRIM_INDEX: o_s_axi_bresp <= `FOB_RESP_OKAY;
                    `FOB_IDX_TRIM_DATA: begin
                        o_s_axi_bresp <= data_ok ? `FOB_RESP_OKAY
                                                 : `FOB_RESP_SLVERR;
                    end
                    // Status words are read-only; writes dropped
                    `FOB_IDX_OPT_STATUS:  o_s_axi_bresp <= `FOB_RESP_OKAY;
                    `FOB_IDX_LIVE_STATUS: o_s_axi_bresp <= `FOB_RESP_OKAY;
                    default:              o_s_axi_bresp <= `FOB_RESP_SLVERR;
                endcase
            end
            if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid  <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready  <= 1'b1;
            end
        end
    end

    // Trim index and data registers
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            trim_index_register_q <= `FOB_TRIM_INDEX_RST;
            trim_data_port_q      <= `FOB_TRIM_DATA_RST; // RULE1
        end else if (state_q == ST_LOAD) begin
            // Recovery discards software trim edits too
            trim_index_register_q <= `FOB_TRIM_INDEX_RST;
            trim_data_port_q      <= `FOB_TRIM_DATA_RST; // RULE21
        end else if (wr_fire && w_lane0_q) begin
            if (aw_idx_q == `FOB_IDX_TRIM_INDEX) begin
                trim_index_register_q <= w_byte_q;
                if (w_byte_q <= `FOB_TRIM_LAST) begin
                    trim_data_port_q <= trim_mem_q[w_byte_q[4:0]]; // RULE20
                end else begin
                    trim_data_port_q <= `FOB_TRIM_DATA_RST;
                end
            end else if (wr_trim_data) begin
                trim_data_port_q <= w_byte_q; // RULE1
            end
        end
    end

    // Read channel, one cycle after the address is taken
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rdata   <= 32'h00000000;
            o_s_axi_rresp   <= `FOB_RESP_OKAY;
        end else begin
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid  <= 1'b1;
                o_s_axi_rresp   <= `FOB_RESP_OKAY;
                case (ar_idx)
                    `FOB_IDX_TRIM_INDEX: begin
                        o_s_axi_rdata <= {24'h000000, trim_index_register_q};
                    end
                    `FOB_IDX_TRIM_DATA: begin
                        o_s_axi_rdata <= {24'h000000, trim_data_port_q}; // RULE20
                    end
                    `FOB_IDX_OPT_STATUS: begin
                        o_s_axi_rdata <= {16'h0000,
                            user_option_byte_1_q | `FOB_B1_RSVD_MASK,
                            user_option_byte_0_q | `FOB_B0_RSVD_MASK}; // RULE13
                    end
                    `FOB_IDX_LIVE_STATUS: begin
                        o_s_axi_rdata <= {27'h0000000, o_xtal_run_in_reset,
                            o_bo_enable, o_wdt_run, state_q, o_opt_loaded};
                    end
                    default: begin
                        o_s_axi_rdata <= 32'h00000000;
                        o_s_axi_rresp <= `FOB_RESP_SLVERR;
                    end
                endcase
            end
            if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid  <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end

    // Watchdog control
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wdt_run       <= 1'b0;
            o_wdt_irq_req   <= 1'b0;
            o_wdt_sys_reset <= 1'b0;
        end else begin
            if (state_q == ST_LOAD) begin
                o_wdt_run <= 1'b0; // RULE6
            end else if (!user_option_byte_0_q[`FOB_B0_WATCHDOG_ALWAYS_ON_SEL]) begin
                o_wdt_run <= 1'b1; // RULE5
            end else if (i_watchdog_start_instruction) begin
                o_wdt_run <= 1'b1; // RULE6
            end
            // Registered one cycle after i_wdt_timeout, high while it stays high; interrupt acceptance is the CPU's business
            o_wdt_irq_req   <= o_wdt_run & i_wdt_timeout
                               & ~user_option_byte_0_q[`FOB_B0_WDT_ACTION]; // RULE3
            o_wdt_sys_reset <= o_wdt_run & i_wdt_timeout
                               & user_option_byte_0_q[`FOB_B0_WDT_ACTION]; // RULE4
        end
    end

    // Static option decode; follows each option byte as soon as it is read, with read, full-debug and programming enables held off while o_opt_loaded is low
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bo_enable         <= 1'b1;
            o_code_read_ok      <= 1'b0;
            o_dbg_full          <= 1'b0;
            o_user_prog_ok      <= 1'b0;
            o_dbg_mass_erase_ok <= 1'b1;
            o_xtal_run_in_reset <= 1'b0;
        end else begin
            o_bo_enable <= user_option_byte_0_q[`FOB_B0_BO_AO]
                           | ~(i_stop_mode & i_pwr_bo_stop_off); // RULE7 RULE8
            // Protection opens only once real options are in
            o_code_read_ok <= o_opt_loaded
                              & user_option_byte_0_q[`FOB_B0_READ_PROT]; // RULE9 RULE10
            o_dbg_full     <= o_opt_loaded
                              & user_option_byte_0_q[`FOB_B0_READ_PROT]; // RULE9 RULE10
            o_user_prog_ok <= o_opt_loaded
                              & user_option_byte_0_q[`FOB_B0_WRITE_PROT]; // RULE11 RULE12
            o_dbg_mass_erase_ok <= 1'b1; // RULE11
            // Only enables the oscillator; clock selection is elsewhere
            o_xtal_run_in_reset <= ~user_option_byte_1_q[`FOB_B1_XTAL_OFF]; // RULE14 RULE15
        end
    end

endmodule

`default_nettype wire

// ==== tb/fob_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module fob_props (
    input wire logic        i_ref_clk, i_rst,
    input wire logic        i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready,
    input wire logic        o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready,
    input wire logic        o_s_axi_rvalid, i_s_axi_rready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic        o_flash_rd, o_flash_info, i_flash_rvalid,
    input wire logic [15:0] o_flash_addr,
    input wire logic        i_stop_recover, i_stop_mode, i_pwr_bo_stop_off, i_wdt_timeout,
    input wire logic        o_opt_loaded, o_wdt_run, o_wdt_irq_req, o_wdt_sys_reset,
    input wire logic        o_bo_enable, o_code_read_ok, o_user_prog_ok, o_xtal_run_in_reset
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire flash_take = o_flash_rd && i_flash_rvalid;
    wire wr_both    = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    wire quiet      = !i_stop_recover && o_opt_loaded;
    sequence s_gap_then_req;
        !o_flash_rd ##1 o_flash_rd;
    endsequence
    sequence s_one_action;
        o_wdt_irq_req ^ o_wdt_sys_reset;
    endsequence
    chk_next_flash_req: assert property (
        flash_take && o_flash_addr != 16'h003F |=> s_gap_then_req) else $error("flash gap");
    chk_load_done: assert property (
        flash_take && o_flash_info && o_flash_addr == 16'h003F |=> o_opt_loaded)
        else $error("load not done");
    chk_flash_hold: assert property (
        o_flash_rd && !i_flash_rvalid |=> o_flash_rd && $stable(o_flash_addr))
        else $error("flash request dropped");
    chk_write_answer: assert property (
        wr_both |=> ##[0:1] o_s_axi_bvalid) else $error("no write response");
    chk_read_answer: assert property (
        i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("no read data");
    chk_rdata_hold: assert property (
        o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data moved");
    chk_bresp_hold: assert property (
        o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response moved");
    chk_wdt_action: assert property (
        i_wdt_timeout && o_wdt_run && quiet |=> s_one_action) else $error("timeout ignored");
    chk_wdt_cause: assert property (
        o_wdt_irq_req || o_wdt_sys_reset |-> $past(i_wdt_timeout)) else $error("stray action");
    chk_bo_kept: assert property (
        !(i_stop_mode && i_pwr_bo_stop_off) |=> o_bo_enable) else $error("brownout off");
    chk_wdt_sticky: assert property (
        o_wdt_run && quiet && !$past(i_stop_recover) |=> o_wdt_run) else $error("wdt stopped");
    chk_opts_frozen: assert property (
        quiet && $past(o_opt_loaded, 2) && !$past(i_stop_recover)
        |=> $stable(o_code_read_ok) && $stable(o_user_prog_ok) && $stable(o_xtal_run_in_reset))
        else $error("options moved");
endmodule
bind fob_option_config fob_props fob_props_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_s_axi_awvalid(i_s_axi_awvalid),
    .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_rdata(o_s_axi_rdata), .o_flash_rd(o_flash_rd), .o_flash_info(o_flash_info),
    .i_flash_rvalid(i_flash_rvalid), .o_flash_addr(o_flash_addr),
    .i_stop_recover(i_stop_recover), .i_stop_mode(i_stop_mode),
    .i_pwr_bo_stop_off(i_pwr_bo_stop_off), .i_wdt_timeout(i_wdt_timeout),
    .o_opt_loaded(o_opt_loaded), .o_wdt_run(o_wdt_run), .o_wdt_irq_req(o_wdt_irq_req),
    .o_wdt_sys_reset(o_wdt_sys_reset), .o_bo_enable(o_bo_enable),
    .o_code_read_ok(o_code_read_ok), .o_user_prog_ok(o_user_prog_ok),
    .o_xtal_run_in_reset(o_xtal_run_in_reset));
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fob_defs.vh"
module tb_top;
    localparam [11:0] TIX = `FOB_IDX_TRIM_INDEX;
    localparam [11:0] TDT = `FOB_IDX_TRIM_DATA;
    localparam [1:0]  OK  = `FOB_RESP_OKAY;
    localparam [1:0]  ER  = `FOB_RESP_SLVERR;
    reg        i_ref_clk = 0, i_rst = 1;
    reg [13:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
    reg [31:0] i_s_axi_wdata = 0;
    reg [3:0]  i_s_axi_wstrb = 0;
    reg        i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
    reg        i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_flash_rvalid = 0;
    reg [7:0]  i_flash_rdata = 0;
    reg        i_stop_recover = 0, i_stop_mode = 0, i_pwr_bo_stop_off = 0;
    reg        i_watchdog_start_instruction = 0, i_wdt_timeout = 0;
    wire       o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    wire       o_s_axi_rvalid, o_flash_rd, o_flash_info, o_opt_loaded, o_wdt_run;
    wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
    wire [31:0] o_s_axi_rdata;
    wire [15:0] o_flash_addr;
    wire       o_wdt_irq_req, o_wdt_sys_reset, o_bo_enable, o_code_read_ok, o_dbg_full;
    wire       o_user_prog_ok, o_dbg_mass_erase_ok, o_xtal_run_in_reset;
    int        n_errors = 0, n_tests = 0, nrd = 0, k;
    reg [7:0]  opt [0:1];
    reg [7:0]  trim [0:31];
    fob_option_config fob_option_config_i (.*);
    initial forever #50 i_ref_clk = ~i_ref_clk;
    task end_of_test;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Flash answers one cycle late; data is scrambled when not valid
    always @(posedge i_ref_clk) begin
        i_flash_rvalid <= o_flash_rd && !i_flash_rvalid;
        i_flash_rdata <= (o_flash_rd && !i_flash_rvalid) ? (o_flash_info ?
            trim[o_flash_addr[4:0]] : opt[o_flash_addr[0]]) : ~i_flash_rdata;
        if (i_rst || i_stop_recover)
            nrd <= 0;
        else if (o_flash_rd && i_flash_rvalid) begin
            chk({o_flash_info, o_flash_addr}, nrd < 2 ? nrd : 32'h1001E + nrd);
            nrd <= nrd + 1;
        end
    end
    task wait_loaded;
        while (!o_opt_loaded) @(posedge i_ref_clk);
        repeat (3) @(posedge i_ref_clk);
    endtask
    task do_reset;
        @(posedge i_ref_clk) i_rst <= 1;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 0;
        wait_loaded;
    endtask
    task axw(input [11:0] idx, input [7:0] d, input [1:0] er);
        @(posedge i_ref_clk);
        i_s_axi_awaddr <= {idx, 2'b00};
        i_s_axi_wdata <= {24'h0, d};
        i_s_axi_wstrb <= 4'hF;
        i_s_axi_awvalid <= 1;
        i_s_axi_wvalid <= 1;
        i_s_axi_bready <= 1;
        do begin
            @(posedge i_ref_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 0;
        end while (!o_s_axi_bvalid);
        i_s_axi_bready <= 0;
        chk(o_s_axi_bresp, er);
    endtask
    task axr(input [11:0] idx, input [31:0] e, input [1:0] er);
        @(posedge i_ref_clk);
        i_s_axi_araddr <= {idx, 2'b00};
        i_s_axi_arvalid <= 1;
        i_s_axi_rready <= 1;
        do begin
            @(posedge i_ref_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 0;
        end while (!o_s_axi_rvalid);
        i_s_axi_rready <= 0;
        chk(o_s_axi_rdata, e);
        chk(o_s_axi_rresp, er);
    endtask
    task test_opts(input [7:0] b0, input [7:0] b1, input by_rst);
        opt[0] = b0;
        opt[1] = b1;
        if (by_rst)
            do_reset;
        else begin
            @(posedge i_ref_clk) i_stop_recover <= 1;
            @(posedge i_ref_clk) i_stop_recover <= 0;
            repeat (2) @(posedge i_ref_clk);
            wait_loaded;
        end
        chk(o_code_read_ok, b0[2]);
        chk(o_dbg_full, b0[2]);
        chk(o_user_prog_ok, b0[0]);
        chk(o_dbg_mass_erase_ok, 1);
        chk(o_xtal_run_in_reset, !b1[4]);
        chk(o_wdt_run, !b0[6]);
        axr(`FOB_IDX_OPT_STATUS, {16'h0, b1 | 8'hEF, b0 | 8'h32}, OK);
        axr(`FOB_IDX_LIVE_STATUS, {27'h0, !b1[4], 1'b1, !b0[6], 2'b11}, OK);
        opt[0] = ~b0;
        repeat (4) @(posedge i_ref_clk);
        chk(o_code_read_ok, b0[2]);
        @(posedge i_ref_clk) i_watchdog_start_instruction <= 1;
        @(posedge i_ref_clk) i_watchdog_start_instruction <= 0;
        #1 chk(o_wdt_run, 1);
        @(posedge i_ref_clk) i_wdt_timeout <= 1;
        @(posedge i_ref_clk) i_wdt_timeout <= 0;
        #1 chk(o_wdt_irq_req, !b0[7]);
        chk(o_wdt_sys_reset, b0[7]);
        @(posedge i_ref_clk) i_stop_mode <= 1;
        i_pwr_bo_stop_off <= 1;
        repeat (3) @(posedge i_ref_clk);
        chk(o_bo_enable, b0[3]);
        i_stop_mode <= 0;
        i_pwr_bo_stop_off <= 0;
        $display("options %h %h done", b0, b1);
    endtask
    task test_trim;
        axr(TDT, 0, OK);
        axr(TIX, 0, OK);
        for (k = 0; k < 2; k++) begin
            axw(TIX, k ? 8'h1F : 8'h05, OK);
            axr(TDT, trim[k ? 31 : 5], OK);
            axw(TDT, 8'h5A + k, OK);
            axw(TIX, k ? 8'h1F : 8'h05, OK);
            axr(TDT, 8'h5A + k, OK);
        end
        axw(TIX, 8'h00, OK);
        axw(TDT, 8'h11, ER);
        axw(TIX, 8'h00, OK);
        axr(TDT, trim[0], OK);
        axw(TIX, 8'h20, OK);
        axr(TDT, 0, OK);
        axw(TDT, 8'h11, ER);
        axr(12'h100, 0, ER);
        // Status word is read-only; the write must leave it alone
        axw(`FOB_IDX_OPT_STATUS, 8'h00, OK);
        axr(`FOB_IDX_OPT_STATUS, 32'h0000FFFF, OK);
        do_reset;
        axw(TIX, 8'h05, OK);
        axr(TDT, trim[5], OK);
        $display("trim access done");
    endtask
    initial begin
        for (k = 0; k < 32; k++) trim[k] = 8'hA0 ^ k;
        test_opts(8'hFF, 8'hFF, 1);
        test_trim;
        test_opts(8'h00, 8'h00, 0);
        end_of_test;
    end
    // Whole run needs a few hundred cycles
    initial begin
        #3000000;
        n_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
